// >>> common/fbsp_regs.vh
// Constants of the flow-through burst SRAM port
`ifndef FBSP_REGS_VH
`define FBSP_REGS_VH

// ********************************************************************
// Array geometry
// ********************************************************************
// Address width of the word array
`define FBSP_ADDR_W 18
// Number of words in the array
`define FBSP_DEPTH 262144
// Number of byte lanes
`define FBSP_LANES 4
// Bits per lane: eight data bits and one parity bit
`define FBSP_LANE_W 9
// Position of the parity bit inside a lane
`define FBSP_LANE_PAR_BIT 8
// Data bus width without parity
`define FBSP_DQ_W 32
// Width of the burst counter
`define FBSP_BURST_W 2

// ********************************************************************
// Reset values
// ********************************************************************
// Burst order after reset: interleaved, as for a floating strap
`define FBSP_ORDER_RST 1'b1
// Read data register after reset
`define FBSP_LANE_RST 9'h000
// Address register after reset
`define FBSP_ADDR_RST 18'h00000
// Burst counter after reset
`define FBSP_BURST_RST 2'h0

// ********************************************************************
// Timing
// ********************************************************************
// Clock period in picoseconds (10 MHz)
`define FBSP_CLK_PS 100000
// Clock rise to read data valid, in picoseconds
`define FBSP_CDV_PS 6500
// Same time as whole cycles, rounded down, never below one
`define FBSP_CDV_CYC (((`FBSP_CDV_PS / `FBSP_CLK_PS) < 1) ? 1 : (`FBSP_CDV_PS / `FBSP_CLK_PS))

`endif

// >>> design/fbsp_burst_ctr.v
// Two-bit wraparound burst counter with linear and interleaved order
`timescale 1ns/10ps
`include "fbsp_regs.vh"

module fbsp_burst_ctr (
  clk_sys,
  rst_n,
  load,
  load_val,
  step,
  order_interleave,
  nxt_low
);
  input wire clk_sys;
  input wire rst_n;
  input wire load;
  input wire [`FBSP_BURST_W-1:0] load_val;
  input wire step;
  input wire order_interleave;
  output reg [`FBSP_BURST_W-1:0] nxt_low;

  // ******************************************************************
  // Order decode
  // ******************************************************************
  // Maps a start value and beat count onto the low address bits
  function [`FBSP_BURST_W-1:0] fbsp_burst_addr;
    input [`FBSP_BURST_W-1:0] start;
    input [`FBSP_BURST_W-1:0] beat;
    input interleave;
    begin
      if (interleave) begin
        fbsp_burst_addr = start ^ beat;
      end else begin
        fbsp_burst_addr = start + beat;
      end
    end
  endfunction

  // ******************************************************************
  // Counter state
  // ******************************************************************
  reg [`FBSP_BURST_W-1:0] start_ff; // First address of the burst
  reg [`FBSP_BURST_W-1:0] beat_ff; // Beats advanced so far
  reg [`FBSP_BURST_W-1:0] nxt_start;
  reg [`FBSP_BURST_W-1:0] nxt_beat;

  // Next start, beat and the address used this cycle
  always @* begin
    nxt_start = start_ff;
    nxt_beat = beat_ff;
    if (load) begin
      nxt_start = load_val;
      nxt_beat = `FBSP_BURST_RST;
    end else if (step) begin
      // Advance one beat; wraps after the fourth
      nxt_beat = beat_ff + 2'h1;
    end
    nxt_low = fbsp_burst_addr(nxt_start, nxt_beat, order_interleave);
  end

  // Counter registers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_ff <= `FBSP_BURST_RST;
      beat_ff <= `FBSP_BURST_RST;
    end else begin
      start_ff <= nxt_start;
      beat_ff <= nxt_beat;
    end
  end

endmodule // fbsp_burst_ctr

// >>> design/fbsp_port.v
// Flow-through burst SRAM access port with array and test port
`timescale 1ns/10ps
`include "fbsp_regs.vh"

module fbsp_port (
  clk_sys,
  rst_n,
  addr,
  chip_sel_a_n,
  chip_sel_b,
  chip_sel_c_n,
  processor_addr_strobe_n,
  controller_addr_strobe_n,
  burst_step_n,
  byte_write_gate_n,
  byte_lane_select_n,
  all_lanes_write_n,
  out_enable_n,
  burst_order_sel,
  dq_in,
  dq_out,
  dq_oe,
  parity_lines_in,
  parity_lines_out,
  parity_lines_oe,
  test_clk,
  test_data_in,
  test_mode_sel,
  test_data_out
);
  input wire clk_sys;
  input wire rst_n;
  input wire [`FBSP_ADDR_W-1:0] addr;
  input wire chip_sel_a_n;
  input wire chip_sel_b;
  input wire chip_sel_c_n;
  input wire processor_addr_strobe_n;
  input wire controller_addr_strobe_n;
  input wire burst_step_n;
  input wire byte_write_gate_n;
  input wire [`FBSP_LANES-1:0] byte_lane_select_n;
  input wire all_lanes_write_n;
  input wire out_enable_n;
  input wire burst_order_sel;
  input wire [`FBSP_DQ_W-1:0] dq_in;
  output wire [`FBSP_DQ_W-1:0] dq_out;
  output wire dq_oe;
  input wire [`FBSP_LANES-1:0] parity_lines_in;
  output wire [`FBSP_LANES-1:0] parity_lines_out;
  output wire parity_lines_oe;
  input wire test_clk;
  input wire test_data_in;
  input wire test_mode_sel;
  output reg test_data_out;

  // ******************************************************************
  // Local states and decode helpers
  // ******************************************************************
  localparam ST_IDLE = 1'b0; // Deselected, no burst open
  localparam ST_ACTIVE = 1'b1; // Burst open, continue cycles allowed

  // All three chip selects active
  function fbsp_cs_ok;
    input sel_a_n;
    input sel_b;
    input sel_c_n;
    begin
      fbsp_cs_ok = ~sel_a_n & sel_b & ~sel_c_n;
    end
  endfunction

  // Lane write enables from the write controls
  function [`FBSP_LANES-1:0] fbsp_lane_we;
    input gw_n;
    input gate_n;
    input [`FBSP_LANES-1:0] sel_n;
    begin
      if (!gw_n) begin
        fbsp_lane_we = 4'hF;
      end else if (!gate_n) begin
        fbsp_lane_we = ~sel_n;
      end else begin
        fbsp_lane_we = 4'h0;
      end
    end
  endfunction

  // ******************************************************************
  // Declarations
  // ******************************************************************
  reg state_ff; // Burst open or not
  reg nxt_state;
  reg order_ff; // Sampled burst-order strap, 1 = interleaved
  reg [`FBSP_ADDR_W-1:0] addr_ff; // Address register
  reg [`FBSP_ADDR_W-1:0] nxt_addr; // Array address used at this edge
  reg read_ff; // A read is driving the data lines this cycle
  reg nxt_read;
  reg [`FBSP_LANES-1:0] nxt_lane_we; // Lanes written at this edge
  reg start_p; // Processor strobe start
  reg start_c; // Controller strobe start
  reg desel; // Strobe seen but selects inactive
  reg step; // Burst advance taken
  reg [`FBSP_LANES-1:0] req_we; // Write controls as presented
  wire cs_all; // All selects active
  wire processor_addr_strobe_n_seen; // Processor strobe not masked by select A
  wire [`FBSP_BURST_W-1:0] burst_low; // Counter output for this edge
  reg tck_ff; // Previous test clock level
  reg tdi_ff; // Test data captured on rise
  reg tms_ff; // Test mode captured on rise

  assign cs_all = fbsp_cs_ok(chip_sel_a_n, chip_sel_b, chip_sel_c_n);
  assign processor_addr_strobe_n_seen = ~processor_addr_strobe_n & ~chip_sel_a_n;

  // ******************************************************************
  // Cycle decode
  // ******************************************************************
  // All inputs but reset and output enable are taken at the coming clock rise; nothing is sampled
  // between edges, so the write needs no external pulse width.
  always @* begin
    start_p = 1'b0;
    start_c = 1'b0;
    desel = 1'b0;
    req_we = fbsp_lane_we(all_lanes_write_n, byte_write_gate_n,
                          byte_lane_select_n);
    if (processor_addr_strobe_n_seen) begin
      if (cs_all) begin
        start_p = 1'b1;
      end else begin
        desel = 1'b1;
      end
    end else if (!controller_addr_strobe_n) begin
      if (cs_all) begin
        start_c = 1'b1;
      end else begin
        desel = 1'b1;
      end
    end
    step = ~burst_step_n & ~start_p & ~start_c & ~desel;
  end

  // Next state, address, write lanes and read flag
  always @* begin
    nxt_state = state_ff;
    nxt_lane_we = 4'h0;
    nxt_read = 1'b0;
    if (start_p || start_c) begin
      nxt_addr = addr;
    end else begin
      nxt_addr = {addr_ff[`FBSP_ADDR_W-1:`FBSP_BURST_W], burst_low};
    end
    case (state_ff)
      ST_IDLE: begin
        // Only a start leaves the deselected state
        if (start_p || start_c) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // A failed select ends the burst
        if (desel) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (start_p) begin
      nxt_read = 1'b1;
    end else if (start_c) begin
      // Host keeps writes off for a read start, so any
      // write control seen here means a write start
      nxt_lane_we = req_we;
      nxt_read = ~(|req_we);
    end else if (!desel && state_ff == ST_ACTIVE) begin
      nxt_lane_we = req_we;
      nxt_read = ~(|req_we);
    end
  end

  // ******************************************************************
  // Burst counter
  // ******************************************************************
  // Counter feeds low bits
  fbsp_burst_ctr u_burst_ctr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(start_p | start_c),
    .load_val(addr[`FBSP_BURST_W-1:0]),
    .step(step),
    .order_interleave(order_ff),
    .nxt_low(burst_low)
  );

  // ******************************************************************
  // Control registers
  // ******************************************************************
  // State, address and read flag update on every rise
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      addr_ff <= `FBSP_ADDR_RST;
      read_ff <= 1'b0;
      order_ff <= `FBSP_ORDER_RST;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      read_ff <= nxt_read;
      // Strap sampled every cycle; it is meant to stay static
      order_ff <= burst_order_sel;
    end
  end

  // ******************************************************************
  // Array lanes and read data
  // ******************************************************************
  // Each lane keeps its own storage so a byte write touches nothing
  // else; read data is taken from the address used at this same edge.
  genvar g;
  generate
    for (g = 0; g < `FBSP_LANES; g = g + 1) begin : g_lane
      reg [`FBSP_LANE_W-1:0] lane_mem [0:`FBSP_DEPTH-1]; // Lane storage
      reg [`FBSP_LANE_W-1:0] rd_ff; // Lane read data
      // Array write; storage has no reset
      always @(posedge clk_sys) begin
        if (nxt_lane_we[g]) begin
          lane_mem[nxt_addr] <= {parity_lines_in[g], dq_in[8*g+7:8*g]};
        end
      end
      // Flow-through read register
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          rd_ff <= `FBSP_LANE_RST;
        end else begin
          rd_ff <= lane_mem[nxt_addr];
        end
      end
      assign dq_out[8*g+7:8*g] = rd_ff[7:0];
      assign parity_lines_out[g] = rd_ff[`FBSP_LANE_PAR_BIT];
    end
  endgenerate

  // ******************************************************************
  // Output enable
  // ******************************************************************
  // Output enable acts without the clock, so these two enables are the only
  // outputs that mix a register with a live input.
  // Float during any write
  assign dq_oe = read_ff & ~out_enable_n;
  assign parity_lines_oe = read_ff & ~out_enable_n;

  // ******************************************************************
  // Test port edges
  // ******************************************************************
  // The test clock is sampled as a plain input, so it must be much
  // slower than the system clock for its edges to be seen.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tck_ff <= 1'b0;
      tdi_ff <= 1'b0;
      tms_ff <= 1'b0;
      test_data_out <= 1'b0;
    end else begin
      tck_ff <= test_clk;
      if (test_clk && !tck_ff) begin
        tdi_ff <= test_data_in;
        tms_ff <= test_mode_sel;
      end
      if (!test_clk && tck_ff && !tms_ff) begin
        test_data_out <= tdi_ff;
      end
    end
  end

endmodule // fbsp_port

// >>> bench/fbsp_chk.sv
// Assertion checker for the flow-through burst SRAM port
`timescale 1ns/10ps
`include "fbsp_regs.vh"

module fbsp_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic byte_write_gate_n,
  input wire logic [`FBSP_LANES-1:0] byte_lane_select_n,
  input wire logic all_lanes_write_n,
  input wire logic out_enable_n,
  input wire logic [`FBSP_DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic parity_lines_oe,
  input wire logic test_clk,
  input wire logic test_data_out
);
  // ********************************************************************
  // Decodes
  // ********************************************************************
  // All three selects active
  wire sel_ok = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  // Processor strobe counts only with select A low
  wire seen_p = !processor_addr_strobe_n && !chip_sel_a_n;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ********************************************************************
  // Properties
  // ********************************************************************
  a_oe_pair: assert property (parity_lines_oe == dq_oe)
    else $error("parity drive differs from data drive");
  a_oe_gate: assert property (out_enable_n |-> !dq_oe)
    else $error("data driven with output enable high");
  a_gw_float: assert property (!all_lanes_write_n && processor_addr_strobe_n
    && (!controller_addr_strobe_n || dq_oe) |=> !dq_oe)
    else $error("data driven after global write");
  a_lane_float: assert property (!controller_addr_strobe_n && processor_addr_strobe_n
    && !byte_write_gate_n && byte_lane_select_n != 4'hF |=> !dq_oe)
    else $error("data driven after byte write");
  a_start_read: assert property ((seen_p && sel_ok) ##1 !out_enable_n |-> dq_oe)
    else $error("processor start did not drive read data");
  a_desel_float: assert property ((seen_p || !controller_addr_strobe_n) && !sel_ok
    |=> !dq_oe)
    else $error("data driven after deselect");
  a_hold_data: assert property (dq_oe && processor_addr_strobe_n
    && controller_addr_strobe_n && burst_step_n && all_lanes_write_n
    && byte_write_gate_n |=> $stable(dq_out))
    else $error("read data moved without advance");
  a_tdo_fall: assert property ($changed(test_data_out) |-> !test_clk)
    else $error("serial output changed while test clock high");
endmodule // fbsp_chk

bind fbsp_port fbsp_chk u_chk (
  .clk_sys, .rst_n, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n,
  .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n,
  .byte_write_gate_n, .byte_lane_select_n, .all_lanes_write_n, .out_enable_n,
  .dq_out, .dq_oe, .parity_lines_oe, .test_clk, .test_data_out
);

// >>> bench/fbsp_host.sv
// Host bus model that drives the burst SRAM port
`timescale 1ns/10ps
`include "fbsp_regs.vh"

module fbsp_host (
  input wire logic clk_sys,
  output logic [`FBSP_ADDR_W-1:0] addr,
  output logic chip_sel_a_n,
  output logic chip_sel_b,
  output logic chip_sel_c_n,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_step_n,
  output logic byte_write_gate_n,
  output logic [`FBSP_LANES-1:0] byte_lane_select_n,
  output logic all_lanes_write_n,
  output wire logic out_enable_n,
  output logic burst_order_sel,
  output wire logic [`FBSP_DQ_W-1:0] dq_in,
  output wire logic [`FBSP_LANES-1:0] parity_lines_in,
  input wire logic [`FBSP_DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic [`FBSP_LANES-1:0] parity_lines_out
);
  // ********************************************************************
  // Data line ownership
  // ********************************************************************
  logic keep_oe = 0; // Leave enable low while driving, a deliberate fault
  logic oe_off = 0; // Hold enable high on reads
  logic drv = 0; // Host owns the data lines
  logic [35:0] hd = 36'h0; // Host write data
  logic [35:0] float_pat = 36'h5_A5A5_A5A5; // Released lines never hold old data
  wire [35:0] bus_lvl = drv ? hd : (dq_oe ? {parity_lines_out, dq_out} : float_pat);

  // Released lines flip every cycle so no stale value can pass
  always @(posedge clk_sys) begin
    float_pat <= ~float_pat;
  end
  assign dq_in = bus_lvl[31:0];
  assign parity_lines_in = bus_lvl[35:32];
  assign out_enable_n = (drv & ~keep_oe) | oe_off;

  initial begin
    {chip_sel_a_n, chip_sel_b, chip_sel_c_n} = 3'b010;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} = 3'b111;
    {all_lanes_write_n, byte_write_gate_n, byte_lane_select_n} = 6'h3F;
    addr = 18'h00000;
    burst_order_sel = 1'b1;
  end

  // One cycle: drive just after a rise, hold through the next rise
  task automatic cyc(input logic p_n, input logic c_n, input logic adv_n,
                     input logic [17:0] a, input logic [5:0] w, input logic [35:0] d);
    processor_addr_strobe_n = p_n;
    controller_addr_strobe_n = c_n;
    burst_step_n = adv_n;
    addr = a;
    {all_lanes_write_n, byte_write_gate_n, byte_lane_select_n} = w;
    hd = d;
    // data only for a write, never in a processor start
    drv = p_n && (!w[5] || (!w[4] && w[3:0] != 4'hF));
    @(posedge clk_sys);
    #1;
  endtask
endmodule // fbsp_host

// >>> bench/tb_fbsp_port.sv
// Testbench for the flow-through burst SRAM port
`timescale 1ns/10ps
`include "fbsp_regs.vh"

module tb_fbsp_port;
  // ********************************************************************
  // Clock, reset and wiring
  // ********************************************************************
  localparam logic [17:0] B = 18'h01230; // Line base, low bits zero
  logic clk_sys = 0;
  logic rst_n = 0;
  logic test_clk = 0;
  logic test_data_in = 0;
  logic test_mode_sel = 0; // Test mode input; high makes the serial output hold
  int err_total = 0;
  int cmp_count = 0;
  wire [17:0] addr;
  wire chip_sel_a_n, chip_sel_b, chip_sel_c_n, processor_addr_strobe_n;
  wire controller_addr_strobe_n, burst_step_n, byte_write_gate_n;
  wire all_lanes_write_n, out_enable_n, burst_order_sel, dq_oe, parity_lines_oe;
  wire test_data_out;
  wire [3:0] byte_lane_select_n, parity_lines_in, parity_lines_out;
  wire [31:0] dq_in, dq_out;
  wire [35:0] rdv = {parity_lines_out, dq_out};

  // Half period of 50 ns
  always #50 clk_sys = ~clk_sys;

  fbsp_port u_dut (.clk_sys, .rst_n, .addr, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n,
    .byte_write_gate_n, .byte_lane_select_n, .all_lanes_write_n, .out_enable_n,
    .burst_order_sel, .dq_in, .dq_out, .dq_oe, .parity_lines_in, .parity_lines_out,
    .parity_lines_oe, .test_clk, .test_data_in, .test_mode_sel, .test_data_out);
  fbsp_host u_host (.clk_sys, .addr, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n,
    .byte_write_gate_n, .byte_lane_select_n, .all_lanes_write_n, .out_enable_n,
    .burst_order_sel, .dq_in, .parity_lines_in, .dq_out, .dq_oe, .parity_lines_out);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [35:0] dat(input int k);
    return 36'hC_A5A5_0000 + 36'(k);
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Data and parity drive enables are compared together
  task automatic oe_is(input logic e);
    chk({34'h0, parity_lines_oe, dq_oe}, {34'h0, e, e});
  endtask
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_fill();
    for (int k = 0; k < 4; k++) begin
      u_host.cyc(1, 0, 1, B + 18'(k), 6'h1F, dat(k));
      oe_is(0);
    end
    $display("test fill done");
  endtask
  // Every start offset in both orders; a held beat between steps
  task automatic t_burst();
    logic [1:0] lo;
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        u_host.burst_order_sel = m[0];
        u_host.cyc(0, 1, 1, B + 18'(s), 6'h3F, 36'h0);
        chk(rdv, dat(s));
        for (int k = 1; k < 4; k++) begin
          lo = m[0] ? 2'(s) ^ 2'(k) : 2'(s + k);
          u_host.cyc(1, 1, 0, 18'h3FFFF, 6'h3F, 36'h0);
          chk(rdv, dat(lo));
          u_host.cyc(1, 1, 1, 18'h3FFFF, 6'h3F, 36'h0);
          chk(rdv, dat(lo));
        end
      end
    end
    $display("test burst done");
  endtask
  // Mid-run reset closes the open burst and clears the read data
  task automatic t_rst();
    rst_n = 0;
    @(posedge clk_sys);
    #1;
    oe_is(0);
    chk(rdv, 36'h0);
    rst_n = 1;
    u_host.cyc(1, 1, 0, B, 6'h3F, 36'h0);
    oe_is(0);
    $display("test reset done");
  endtask
  task automatic t_wr();
    u_host.cyc(0, 1, 1, B, 6'h1F, 36'h1_2345_6789);
    oe_is(1);
    chk(rdv, dat(0));
    // Enable left low on purpose: device must float on its own
    u_host.keep_oe = 1;
    u_host.cyc(1, 1, 1, 18'h3FFFF, 6'h1F, 36'h1_2345_6789);
    oe_is(0);
    u_host.keep_oe = 0;
    u_host.cyc(1, 0, 1, B, 6'h3F, 36'h0);
    chk(rdv, 36'h1_2345_6789);
    u_host.cyc(0, 0, 1, B + 18'h1, 6'h1F, 36'h0);
    chk(rdv, dat(1));
    oe_is(1);
    $display("test write done");
  endtask
  task automatic t_byte();
    u_host.cyc(1, 0, 1, B + 18'h2, 6'h2A, 36'hF_FFFF_FFFF);
    oe_is(0);
    u_host.cyc(1, 0, 1, B + 18'h2, 6'h30, 36'h0);
    oe_is(1);
    chk(rdv, dat(2) | 36'h5_00FF_00FF);
    $display("test byte done");
  endtask
  task automatic t_desel();
    // Processor strobe with select A high is dropped, so the burst steps on
    u_host.chip_sel_a_n = 1;
    u_host.cyc(0, 1, 0, B, 6'h3F, 36'h0);
    chk(rdv, dat(3));
    oe_is(1);
    for (int i = 0; i < 3; i++) begin
      {u_host.chip_sel_a_n, u_host.chip_sel_b, u_host.chip_sel_c_n} = 3'b010 ^ (3'b100 >> i);
      u_host.cyc(0, 0, 1, B, 6'h3F, 36'h0);
      oe_is(0);
      u_host.cyc(1, 1, 0, B, 6'h3F, 36'h0);
      oe_is(0);
    end
    {u_host.chip_sel_a_n, u_host.chip_sel_b, u_host.chip_sel_c_n} = 3'b010;
    $display("test deselect done");
  endtask
  task automatic t_oe();
    u_host.oe_off = 1;
    u_host.cyc(0, 1, 1, B + 18'h3, 6'h3F, 36'h0);
    oe_is(0);
    u_host.oe_off = 0;
    #1;
    oe_is(1);
    chk(rdv, dat(3));
    u_host.cyc(1, 1, 1, B, 6'h3F, 36'h0);
    $display("test enable done");
  endtask
  // Test clock levels last four system clocks, well above the one needed
  task automatic t_tap();
    for (int b = 0; b < 3; b++) begin
      test_data_in = ~b[0];
      test_mode_sel = (b == 2);
      test_clk = 1;
      repeat (4) @(posedge clk_sys);
      #1;
      test_clk = 0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk({35'h0, test_data_out}, {35'h0, (b < 2) ? ~b[0] : 1'b0});
    end
    $display("test scan done");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1;
    t_fill();
    t_burst();
    t_rst();
    t_wr();
    t_byte();
    t_desel();
    t_oe();
    t_tap();
    print_verdict();
  end
  // Watchdog: tests need about 110 cycles, allow 2000
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule // tb_fbsp_port
